// ==== core/tcd_pkg.sv ====
// Purpose: constants and types shared by the two-channel dma controller
// Assumes: 32-bit register port, word-aligned offsets
// Notes:   values below are widths, register layout, source codes, reset values and sequencer states
package tcd_pkg;

    //----------------------------------------
    // widths
    //----------------------------------------
    localparam int  DW         = 32;
    localparam int  RAW        = 8;
    localparam int  MAW        = 20;
    localparam int  CW         = 16;
    localparam int  SELW       = 5;
    localparam int  NUM_PERIPH = 19;

    //----------------------------------------
    // register map
    //----------------------------------------
    localparam logic [RAW-1:0] CH_STRIDE = 8'h20;
    localparam logic [4:0]     OFF_CTRL  = 5'h00;
    localparam logic [4:0]     OFF_SRC   = 5'h04;
    localparam logic [4:0]     OFF_DST   = 5'h08;
    localparam logic [4:0]     OFF_CNT   = 5'h0c;
    localparam logic [4:0]     OFF_RLD   = 5'h10;
    localparam logic [4:0]     OFF_SEL   = 5'h14;

    //----------------------------------------
    // control register fields
    //----------------------------------------
    localparam int  B_BYTE  = 0;
    localparam int  B_RPT   = 1;
    localparam int  B_REQ   = 2;
    localparam int  B_EN    = 3;
    localparam int  B_SFWD  = 4;
    localparam int  B_DFWD  = 5;
    localparam int  B_SWREQ = 6;

    //----------------------------------------
    // request source codes
    //----------------------------------------
    localparam logic [SELW-1:0] SRC_SW        = 5'h00;
    localparam logic [SELW-1:0] SRC_EXT0_FALL = 5'h01;
    localparam logic [SELW-1:0] SRC_EXT0_BOTH = 5'h02;
    localparam logic [SELW-1:0] SRC_EXT1_FALL = 5'h03;
    localparam logic [SELW-1:0] SRC_PERIPH    = 5'h04;

    //----------------------------------------
    // reset values
    //----------------------------------------
    localparam logic [MAW-1:0]  RST_PTR = 20'h00000;
    localparam logic [CW-1:0]   RST_CNT = 16'h0000;
    localparam logic [SELW-1:0] RST_SEL = 5'h00;
    localparam logic            RST_PIN = 1'b1;

    //----------------------------------------
    // transfer sequencer
    //----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_READ   = 3'b001,
        ST_LATCH  = 3'b011,
        ST_WRITE  = 3'b010,
        ST_UPDATE = 3'b110
    } tcd_state_t;

    // step a forward pointer by one or two bytes, wrapping in 1M bytes
    function automatic logic [MAW-1:0] tcd_step(input logic [MAW-1:0] p, input logic is_byte);
        tcd_step = p + (is_byte ? 20'h00001 : 20'h00002);
    endfunction

endpackage

// ==== core/tcd_req_sel.sv ====
// Purpose: per-channel request source selection and pin edge detection
// Assumes: pins and peripheral requests synchronous to the clock
// Notes:   peripheral requests are one-cycle pulses
`timescale 1ns/1ps
module tcd_req_sel #(
    parameter int NP = tcd_pkg::NUM_PERIPH
) (
    // clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_rst,
    // selection and sources
    input  wire logic [tcd_pkg::SELW-1:0]  i_sel,
    input  wire logic                      i_sw,
    input  wire logic                      i_pin0,
    input  wire logic                      i_pin1,
    input  wire logic [NP-1:0]             i_periph,
    // selected request pulse
    output logic                           o_req
);
    import tcd_pkg::*;

    logic pin0_q;
    logic pin1_q;
    logic pin0_d;
    logic pin1_d;

    // previous pin levels for edge detection
    always_comb begin
        pin0_d = i_pin0;
        pin1_d = i_pin1;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pin0_q <= RST_PIN;
            pin1_q <= RST_PIN;
        end else begin
            pin0_q <= pin0_d;
            pin1_q <= pin1_d;
        end
    end

    always_comb begin
        o_req = 1'b0;
        if (i_sel == SRC_SW) begin
            o_req = i_sw;
        end else if (i_sel == SRC_EXT0_FALL) begin
            o_req = pin0_q & ~i_pin0;
        end else if (i_sel == SRC_EXT0_BOTH) begin
            o_req = pin0_q ^ i_pin0;
        end else if (i_sel == SRC_EXT1_FALL) begin
            o_req = pin1_q & ~i_pin1;
        end else if (i_sel < SELW'(SRC_PERIPH + NP)) begin
            o_req = i_periph[i_sel - SRC_PERIPH];
        end
    end

endmodule

// ==== core/tcd_arb.sv ====
// Purpose: fixed priority pick between the two channels
// Assumes: pending vectors are levels
// Notes:   pure combinational
`timescale 1ns/1ps
module tcd_arb (
    // pending channels
    input  wire logic [1:0] i_pend,
    // winner
    output logic            o_any,
    output logic            o_ch
);
    always_comb begin
        o_any = |i_pend;
        o_ch  = ~i_pend[0];
    end

endmodule

// ==== core/tcd_dma.sv ====
// Purpose: two-channel cycle-stealing dma controller with register port
// Assumes: memory answers a read with data in the next cycle, never stalls
// Notes:   one unit takes five clocks; bus held from read to update
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
module tcd_dma #(
    parameter int NP = tcd_pkg::NUM_PERIPH
) (
    // clock and reset
    input  wire logic                      I_CORE_CLK,
    input  wire logic                      I_RST,
    // register port
    input  wire logic [tcd_pkg::RAW-1:0]   I_ADDR,
    input  wire logic [tcd_pkg::DW-1:0]    I_WDATA,
    input  wire logic                      I_WR,
    input  wire logic                      I_RD,
    output logic      [tcd_pkg::DW-1:0]    O_RDATA,
    // request sources
    input  wire logic                      I_EXT_IRQ_PIN_ZERO,
    input  wire logic                      I_EXT_IRQ_PIN_ONE,
    input  wire logic [NP-1:0]             I_PERIPH_IRQ,
    // shared data bus
    output logic                           O_CPU_HOLD,
    output logic      [tcd_pkg::MAW-1:0]   O_MEM_ADDR,
    output logic                           O_MEM_RD,
    output logic                           O_MEM_WR,
    output logic                           O_MEM_WORD,
    output logic      [15:0]               O_MEM_WDATA,
    input  wire logic [15:0]               I_MEM_RDATA,
    // end-of-run pulses
    output logic      [1:0]                O_CH_IRQ
);
    import tcd_pkg::*;

    //----------------------------------------
    // state
    //----------------------------------------
    logic [MAW-1:0]  src_q    [2];
    logic [MAW-1:0]  src_d    [2];
    logic [MAW-1:0]  dst_q    [2];
    logic [MAW-1:0]  dst_d    [2];
    logic [MAW-1:0]  fwd_q    [2];
    logic [MAW-1:0]  fwd_d    [2];
    logic [CW-1:0]   cnt_q    [2];
    logic [CW-1:0]   cnt_d    [2];
    logic [CW-1:0]   rld_q    [2];
    logic [CW-1:0]   rld_d    [2];
    logic [SELW-1:0] sel_q    [2];
    logic [SELW-1:0] sel_d    [2];
    logic [1:0]      byte_q;
    logic [1:0]      byte_d;
    logic [1:0]      rpt_q;
    logic [1:0]      rpt_d;
    logic [1:0]      req_q;
    logic [1:0]      req_d;
    logic [1:0]      en_q;
    logic [1:0]      en_d;
    logic [1:0]      sfwd_q;
    logic [1:0]      sfwd_d;
    logic [1:0]      dfwd_q;
    logic [1:0]      dfwd_d;
    logic [1:0]      first_q;
    logic [1:0]      first_d;
    tcd_state_t      st_q;
    tcd_state_t      st_d;
    logic            ch_q;
    logic            ch_d;
    logic [MAW-1:0]  csrc_q;
    logic [MAW-1:0]  csrc_d;
    logic [MAW-1:0]  cdst_q;
    logic [MAW-1:0]  cdst_d;
    logic [15:0]     data_q;
    logic [15:0]     data_d;
    logic [DW-1:0]   rdata_d;
    logic            hold_d;
    logic [MAW-1:0]  maddr_d;
    logic            mrd_d;
    logic            mwr_d;
    logic            mword_d;
    logic [1:0]      irq_d;

    //----------------------------------------
    // request selection and arbitration
    //----------------------------------------
    logic [1:0] sw_hit;
    logic [1:0] ev;
    logic [1:0] pend;
    logic       any_pend;
    logic       win_ch;
    logic       hit;
    logic       rch;
    logic [4:0] roff;

    // register decode: bit 5 picks the channel, upper bits must be zero
    assign hit  = (I_ADDR[RAW-1:6] == 2'h0);
    assign rch  = I_ADDR[5];
    assign roff = I_ADDR[4:0];

    assign sw_hit[0] = I_WR & hit & ~rch & (roff == OFF_CTRL) & I_WDATA[B_SWREQ];
    assign sw_hit[1] = I_WR & hit & rch & (roff == OFF_CTRL) & I_WDATA[B_SWREQ];

    assign pend = req_q & en_q;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sel
            tcd_req_sel #(
                .NP (NP)
            ) u_sel (
                .i_clk    (I_CORE_CLK),
                .i_rst    (I_RST),
                .i_sel    (sel_q[g]),
                .i_sw     (sw_hit[g]),
                .i_pin0   (I_EXT_IRQ_PIN_ZERO),
                .i_pin1   (I_EXT_IRQ_PIN_ONE),
                .i_periph (I_PERIPH_IRQ),
                .o_req    (ev[g])
            );
        end
    endgenerate

    tcd_arb u_arb (
        .i_pend (pend),
        .o_any  (any_pend),
        .o_ch   (win_ch)
    );

    //----------------------------------------
    // next-state logic
    //----------------------------------------
    always_comb begin
        logic [MAW-1:0] f;
        f       = RST_PTR;
        src_d   = src_q;
        dst_d   = dst_q;
        fwd_d   = fwd_q;
        cnt_d   = cnt_q;
        rld_d   = rld_q;
        sel_d   = sel_q;
        byte_d  = byte_q;
        rpt_d   = rpt_q;
        req_d   = req_q;
        en_d    = en_q;
        sfwd_d  = sfwd_q;
        dfwd_d  = dfwd_q;
        first_d = first_q;
        st_d    = st_q;
        ch_d    = ch_q;
        csrc_d  = csrc_q;
        cdst_d  = cdst_q;
        data_d  = data_q;
        rdata_d = '0;
        maddr_d = O_MEM_ADDR;
        mrd_d   = 1'b0;
        mwr_d   = 1'b0;
        mword_d = O_MEM_WORD;
        irq_d   = 2'b00;

        // one unit per grant, bus returned between units
        // no interrupt enable or level takes part here
        unique case (st_q)
            ST_IDLE: begin
                if (any_pend) begin
                    ch_d = win_ch;
                    req_d[win_ch] = 1'b0;
                    f = fwd_q[win_ch];
                    if (first_q[win_ch]) begin
                        f = sfwd_q[win_ch] ? src_q[win_ch] : dst_q[win_ch];
                        cnt_d[win_ch] = rld_q[win_ch];
                        first_d[win_ch] = 1'b0;
                    end
                    fwd_d[win_ch] = f;
                    csrc_d  = sfwd_q[win_ch] ? f : src_q[win_ch];
                    cdst_d  = dfwd_q[win_ch] ? f : dst_q[win_ch];
                    maddr_d = csrc_d;
                    mword_d = ~byte_q[win_ch];
                    mrd_d   = 1'b1;
                    st_d    = ST_READ;
                end
            end
            ST_READ: begin
                st_d = ST_LATCH;
            end
            ST_LATCH: begin
                data_d  = byte_q[ch_q] ? {8'h00, I_MEM_RDATA[7:0]} : I_MEM_RDATA;
                maddr_d = cdst_q;
                mwr_d   = 1'b1;
                st_d    = ST_WRITE;
            end
            ST_WRITE: begin
                st_d = ST_UPDATE;
            end
            ST_UPDATE: begin
                fwd_d[ch_q] = tcd_step(fwd_q[ch_q], byte_q[ch_q]);
                if (cnt_q[ch_q] == RST_CNT) begin
                    irq_d[ch_q] = 1'b1;
                    if (rpt_q[ch_q]) begin
                        cnt_d[ch_q] = rld_q[ch_q];
                    end else begin
                        en_d[ch_q] = 1'b0;
                        cnt_d[ch_q] = cnt_q[ch_q] - 16'h0001;
                    end
                end else begin
                    cnt_d[ch_q] = cnt_q[ch_q] - 16'h0001;
                end
                st_d = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase

        // processor held off while a unit is in flight
        hold_d = (st_d != ST_IDLE);

        // register writes
        if (I_WR && hit) begin
            unique case (roff)
                OFF_CTRL: begin
                    byte_d[rch] = I_WDATA[B_BYTE];
                    rpt_d[rch]  = I_WDATA[B_RPT];
                    sfwd_d[rch] = I_WDATA[B_SFWD];
                    dfwd_d[rch] = I_WDATA[B_DFWD];
                    en_d[rch]   = I_WDATA[B_EN];
                    // enable write restarts from initial state
                    if (I_WDATA[B_EN]) begin
                        first_d[rch] = 1'b1;
                    end
                    // clear only, a one is ignored
                    if (!I_WDATA[B_REQ]) begin
                        req_d[rch] = 1'b0;
                    end
                end
                OFF_SRC: begin
                    if (sfwd_q[rch] || !en_q[rch]) begin
                        src_d[rch] = I_WDATA[MAW-1:0];
                    end
                end
                OFF_DST: begin
                    if (dfwd_q[rch] || !en_q[rch]) begin
                        dst_d[rch] = I_WDATA[MAW-1:0];
                    end
                end
                OFF_CNT: begin
                    rld_d[rch] = I_WDATA[CW-1:0];
                end
                OFF_SEL: begin
                    sel_d[rch] = I_WDATA[SELW-1:0];
                end
                default: begin
                end
            endcase
        end

        // sticky flag, new request beats any clear
        req_d = req_d | ev;

        // every register readable, working pointer shown when active
        if (I_RD && hit) begin
            unique case (roff)
                OFF_CTRL: begin
                    rdata_d[B_BYTE] = byte_q[rch];
                    rdata_d[B_RPT]  = rpt_q[rch];
                    rdata_d[B_REQ]  = req_q[rch];
                    rdata_d[B_EN]   = en_q[rch];
                    rdata_d[B_SFWD] = sfwd_q[rch];
                    rdata_d[B_DFWD] = dfwd_q[rch];
                end
                OFF_SRC: begin
                    rdata_d[MAW-1:0] = (en_q[rch] && sfwd_q[rch]) ? fwd_q[rch] : src_q[rch];
                end
                OFF_DST: begin
                    rdata_d[MAW-1:0] = (en_q[rch] && dfwd_q[rch]) ? fwd_q[rch] : dst_q[rch];
                end
                OFF_CNT: begin
                    rdata_d[CW-1:0] = cnt_q[rch];
                end
                OFF_RLD: begin
                    rdata_d[CW-1:0] = rld_q[rch];
                end
                OFF_SEL: begin
                    rdata_d[SELW-1:0] = sel_q[rch];
                end
                default: begin
                end
            endcase
        end
    end

    //----------------------------------------
    // registers
    //----------------------------------------
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            for (int i = 0; i < 2; i++) begin
                src_q[i] <= RST_PTR;
                dst_q[i] <= RST_PTR;
                fwd_q[i] <= RST_PTR;
                cnt_q[i] <= RST_CNT;
                rld_q[i] <= RST_CNT;
                sel_q[i] <= RST_SEL;
            end
            byte_q      <= 2'b00;
            rpt_q       <= 2'b00;
            req_q       <= 2'b00;
            en_q        <= 2'b00;
            sfwd_q      <= 2'b00;
            dfwd_q      <= 2'b00;
            first_q     <= 2'b00;
            st_q        <= ST_IDLE;
            ch_q        <= 1'b0;
            csrc_q      <= RST_PTR;
            cdst_q      <= RST_PTR;
            data_q      <= 16'h0000;
            O_RDATA     <= '0;
            O_CPU_HOLD  <= 1'b0;
            O_MEM_ADDR  <= RST_PTR;
            O_MEM_RD    <= 1'b0;
            O_MEM_WR    <= 1'b0;
            O_MEM_WORD  <= 1'b0;
            O_MEM_WDATA <= 16'h0000;
            O_CH_IRQ    <= 2'b00;
        end else begin
            src_q       <= src_d;
            dst_q       <= dst_d;
            fwd_q       <= fwd_d;
            cnt_q       <= cnt_d;
            rld_q       <= rld_d;
            sel_q       <= sel_d;
            byte_q      <= byte_d;
            rpt_q       <= rpt_d;
            req_q       <= req_d;
            en_q        <= en_d;
            sfwd_q      <= sfwd_d;
            dfwd_q      <= dfwd_d;
            first_q     <= first_d;
            st_q        <= st_d;
            ch_q        <= ch_d;
            csrc_q      <= csrc_d;
            cdst_q      <= cdst_d;
            data_q      <= data_d;
            O_RDATA     <= rdata_d;
            O_CPU_HOLD  <= hold_d;
            O_MEM_ADDR  <= maddr_d;
            O_MEM_RD    <= mrd_d;
            O_MEM_WR    <= mwr_d;
            O_MEM_WORD  <= mword_d;
            O_MEM_WDATA <= data_d;
            O_CH_IRQ    <= irq_d;
        end
    end

endmodule

// ==== test/tcd_dma_sva.sv ====
// Purpose: bus-side timing checks for the dma controller
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to the top module at the foot of this file
`timescale 1ns/1ps
module tcd_dma_sva (
    // clock and reset
    input wire logic                    I_CORE_CLK,
    input wire logic                    I_RST,
    // watched ports
    input wire logic                    I_RD,
    input wire logic [tcd_pkg::DW-1:0]  O_RDATA,
    input wire logic                    O_CPU_HOLD,
    input wire logic                    O_MEM_RD,
    input wire logic                    O_MEM_WR,
    input wire logic [1:0]              O_CH_IRQ
);
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_RST);

    //----------------------------------------
    // unit transfer steps
    //----------------------------------------
    // one idle bus cycle between source read and destination write
    sequence rd_gap_wr;
        !O_MEM_WR ##1 O_MEM_WR;
    endsequence
    // processor kept off the bus for exactly four cycles
    sequence held_unit;
        O_CPU_HOLD [*4] ##1 !O_CPU_HOLD;
    endsequence

    bus_excl_a: assert property (!(O_MEM_RD && O_MEM_WR))
        else $error("memory read and write together");
    hold_unit_a: assert property ($rose(O_CPU_HOLD) |-> O_MEM_RD ##0 held_unit)
        else $error("bus hold not four cycles from the read");
    wr_in_hold_a: assert property (O_MEM_WR |-> O_CPU_HOLD)
        else $error("memory write without bus hold");
    rd_wr_order_a: assert property (O_MEM_RD |=> rd_gap_wr)
        else $error("write not two cycles after read");
    wr_gap_a: assert property (O_MEM_WR |=> !O_MEM_WR [*4])
        else $error("unit writes closer than five cycles");
    irq_after_wr_a: assert property (|O_CH_IRQ |-> $past(O_MEM_WR, 2))
        else $error("end-of-run pulse without a write");
    irq_hold_drop_a: assert property (|O_CH_IRQ |-> $fell(O_CPU_HOLD))
        else $error("end-of-run pulse not at bus release");
    irq_onehot_a: assert property ($onehot0(O_CH_IRQ))
        else $error("both channels ended in one cycle");
    rdata_idle_a: assert property (!$past(I_RD) |-> O_RDATA == '0)
        else $error("read data outside its cycle");
endmodule

bind tcd_dma tcd_dma_sva u_sva (
    .I_CORE_CLK (I_CORE_CLK),
    .I_RST      (I_RST),
    .I_RD       (I_RD),
    .O_RDATA    (O_RDATA),
    .O_CPU_HOLD (O_CPU_HOLD),
    .O_MEM_RD   (O_MEM_RD),
    .O_MEM_WR   (O_MEM_WR),
    .O_CH_IRQ   (O_CH_IRQ)
);

// ==== test/tcd_mem_model.sv ====
// Purpose: memory answering the controller's source reads
// Assumes: read data wanted in the cycle after the read strobe
// Notes:   content is a fixed pattern of the address, writes are judged by the bench
`timescale 1ns/1ps
module tcd_mem_model (
    // clock
    input  wire logic        i_clk,
    // controller side
    input  wire logic        i_rd,
    input  wire logic [19:0] i_addr,
    // read data
    output logic      [15:0] o_rdata
);
    initial o_rdata = 16'h0000;
    // any address answers; stale data flips each cycle so a one-cycle slip never passes as valid
    always @(posedge i_clk) begin
        if (i_rd) begin
            o_rdata <= i_addr[15:0] ^ 16'h5a5a;
        end else begin
            o_rdata <= ~o_rdata;
        end
    end
endmodule

// ==== test/testbench.sv ====
// Purpose: self-checking bench for the two-channel dma controller
// Assumes: register port and memory protocol as handed over
// Notes:   each scenario is its own task
`timescale 1ns/1ps
module testbench;
    import tcd_pkg::*;
    logic clk, rst, wr, rd, p0, p1, mrd, mwr, hold, mword;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, d;
    logic [18:0] periph;
    logic [19:0] maddr;
    logic [15:0] mwdata, mrdata;
    logic [1:0] chirq;
    int error_cnt, check_count, irq0, irq1;

    tcd_dma dut (.I_CORE_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_EXT_IRQ_PIN_ZERO(p0),
        .I_EXT_IRQ_PIN_ONE(p1), .I_PERIPH_IRQ(periph), .O_CPU_HOLD(hold),
        .O_MEM_ADDR(maddr), .O_MEM_RD(mrd), .O_MEM_WR(mwr), .O_MEM_WORD(mword),
        .O_MEM_WDATA(mwdata), .I_MEM_RDATA(mrdata), .O_CH_IRQ(chirq));
    tcd_mem_model u_mem (.i_clk(clk), .i_rd(mrd), .i_addr(maddr), .o_rdata(mrdata));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // count end-of-run pulses per channel
    always @(posedge clk) begin
        if (chirq[0] === 1'b1) irq0++;
        if (chirq[1] === 1'b1) irq1++;
    end

    function automatic logic [15:0] pat(input logic [19:0] a);
        return a[15:0] ^ 16'h5a5a;
    endfunction
    task automatic tally_and_finish();
        if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= v; end
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a);
        @(posedge clk) begin rd <= 1'b1; addr <= a; end
        @(posedge clk) rd <= 1'b0;
        #1 d = rdata;
    endtask
    // bounded wait for one unit write, then judge it
    task automatic wait_wr(input logic [19:0] ea, input logic [15:0] ed, input logic byt);
        int i;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            #1;
            if (mwr === 1'b1) break;
        end
        if (i == 40) begin
            error_cnt++;
            $display("CHECK FAILED unit write expected 1 seen 0");
            tally_and_finish();
        end
        chk("dest addr", ea, maddr);
        chk("data", byt ? ed[7:0] : ed, byt ? mwdata[7:0] : mwdata);
        chk("unit size", !byt, mword);
        chk("bus hold", 1, hold);
    endtask
    task automatic no_wr();
        repeat (15) begin
            @(posedge clk);
            #1 chk("no write", 0, mwr);
        end
    endtask

    task automatic sc_regs();
        rreg(8'h00); chk("ctrl reset", 0, d);
        wreg(8'h18, 32'hffffffff);
        rreg(8'h18); chk("unmapped", 0, d);
    endtask
    task automatic sc_flag();
        wreg(8'h00, 32'h40);
        rreg(8'h00); chk("req flag", 1, d[B_REQ]);
        no_wr();
        wreg(8'h00, 32'h0);
        wreg(8'h00, 32'h4);
        rreg(8'h00); chk("req flag", 0, d[B_REQ]);
    endtask
    task automatic sc_single();
        wreg(8'h14, 32'h2); wreg(8'h04, 32'h100); wreg(8'h08, 32'h2000);
        wreg(8'h0c, 32'h1); wreg(8'h00, 32'h18);
        @(posedge clk) p0 <= 1'b0;
        wait_wr(20'h2000, pat(20'h100), 1'b0);
        wreg(8'h08, 32'h3000);
        @(posedge clk) p0 <= 1'b1;
        wait_wr(20'h2000, pat(20'h102), 1'b0);
        repeat (3) @(posedge clk);
        #1 chk("irq0", 1, irq0);
        rreg(8'h00); chk("enable", 0, d[B_EN]);
        rreg(8'h0c); chk("counter", 32'hffff, d);
        rreg(8'h08); chk("fixed dst", 32'h2000, d);
    endtask
    task automatic sc_repeat();
        wreg(8'h34, 32'h3); wreg(8'h24, 32'h50); wreg(8'h28, 32'h400);
        wreg(8'h2c, 32'h0); wreg(8'h20, 32'h2b);
        @(posedge clk) p1 <= 1'b0;
        wait_wr(20'h400, pat(20'h50), 1'b1);
        @(posedge clk) p1 <= 1'b1;
        no_wr();
        @(posedge clk) p1 <= 1'b0;
        wait_wr(20'h401, pat(20'h50), 1'b1);
        repeat (3) @(posedge clk);
        #1 chk("irq1", 2, irq1);
        rreg(8'h20); chk("enable", 1, d[B_EN]);
        wreg(8'h20, 32'h2b);
        @(posedge clk) p1 <= 1'b1;
        @(posedge clk) p1 <= 1'b0;
        wait_wr(20'h400, pat(20'h50), 1'b1);
        wreg(8'h20, 32'h0);
    endtask
    task automatic sc_prio();
        // pointers other than channel 0's source 0x10 kept clear of the controller's own register range
        wreg(8'h04, 32'h10); wreg(8'h08, 32'h120);
        wreg(8'h24, 32'h130); wreg(8'h28, 32'h40);
        for (int k = 0; k < 19; k++) begin
            wreg(8'h14, 32'(k + 4)); wreg(8'h34, 32'(k + 4));
            wreg(8'h00, 32'h0a); wreg(8'h20, 32'h0a);
            @(posedge clk) periph[k] <= 1'b1;
            @(posedge clk) periph <= '0;
            wait_wr(20'h120, pat(20'h10), 1'b0);
            wait_wr(20'h40, pat(20'h130), 1'b0);
        end
        wreg(8'h14, 32'd23); wreg(8'h34, 32'd31);
        @(posedge clk) periph <= '1;
        @(posedge clk) periph <= '0;
        no_wr();
    endtask
    // pin 0 falling-edge source: fall requests, rise does not
    task automatic sc_fall0();
        wreg(8'h14, 32'h1);
        @(posedge clk) p0 <= 1'b0;
        wait_wr(20'h120, pat(20'h10), 1'b0);
        @(posedge clk) p0 <= 1'b1;
        no_wr();
        wreg(8'h00, 32'h0); wreg(8'h20, 32'h0);
    endtask

    initial begin
        rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
        p0 = 1'b1; p1 = 1'b1; periph = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        sc_regs();
        sc_flag();
        sc_single();
        sc_repeat();
        sc_prio();
        sc_fall0();
        tally_and_finish();
    end
endmodule
